// ---- design/config_port_pkg.sv ----
package config_port_pkg;

	// ------------------------------------------------------------
	// Frame layout
	// ------------------------------------------------------------
	localparam int unsigned ADDR_BITS  = 8;
	localparam int unsigned DATA_BITS  = 16;
	localparam int unsigned FRAME_BITS = ADDR_BITS + DATA_BITS;
	localparam int unsigned RW_POS     = 7;

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [6:0] OFS_IFACE_FILTER   = 7'h00;
	localparam logic [6:0] OFS_CORR_FORMAT    = 7'h01;
	localparam logic [6:0] OFS_OVR_THRESH     = 7'h02;
	localparam logic [6:0] OFS_CHA_CORR       = 7'h03;
	localparam logic [6:0] OFS_SYNC_LOW       = 7'h0e;
	localparam logic [6:0] OFS_SYNC_HIGH_REF  = 7'h0f;
	localparam logic [6:0] OFS_CHB_CORR       = 7'h1a;
	localparam logic [6:0] OFS_TEMPERATURE    = 7'h2b;
	localparam logic [6:0] OFS_SOFT_RESET     = 7'h2c;
	localparam logic [6:0] OFS_SLEEP_MODE     = 7'h37;
	localparam logic [6:0] OFS_BIAS_POWER     = 7'h38;
	localparam logic [6:0] OFS_OUT_DRIVER     = 7'h3a;
	localparam logic [6:0] OFS_CHA_PINS       = 7'h66;
	localparam logic [6:0] OFS_CHB_PINS       = 7'h67;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [15:0] RST_IFACE_FILTER  = 16'h0000;
	localparam logic [15:0] RST_CORR_FORMAT   = 16'h0000;
	localparam logic [15:0] RST_OVR_THRESH    = 16'h0780;
	localparam logic [15:0] RST_CHA_CORR      = 16'h4b18;
	localparam logic [15:0] RST_SYNC_LOW      = 16'haaa8;
	localparam logic [15:0] RST_SYNC_HIGH_REF = 16'ha000;
	localparam logic [15:0] RST_CHB_CORR      = 16'h4b18;
	localparam logic [15:0] RST_SLEEP_MODE    = 16'h0000;
	localparam logic [15:0] RST_BIAS_POWER    = 16'hffb0;
	localparam logic [15:0] RST_OUT_DRIVER    = 16'h081b;
	localparam logic [15:0] RST_PINS          = 16'hffff;
	localparam logic [15:0] SOFT_RESET_KEY    = 16'hd2f0;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int unsigned FLD_FOUR_WIRE     = 15;
	localparam int unsigned FLD_DECIMATE      = 14;
	localparam int unsigned FLD_CHA_FILTER    = 12;
	localparam int unsigned FLD_CHB_FILTER    = 9;
	localparam int unsigned FLD_CHA_AUTOCORR  = 15;
	localparam int unsigned FLD_CHB_AUTOCORR  = 9;
	localparam int unsigned FLD_PERF_ONE      = 1;
	localparam int unsigned FLD_OVR_LSB       = 7;
	localparam int unsigned FLD_OFFSET_LOOP   = 14;
	localparam int unsigned FLD_SYNC_LSB      = 2;

	localparam logic [13:0] SYNC_DISABLED     = 14'h0000;
	localparam logic [13:0] SYNC_ONE_SHOT     = 14'h1555;
	localparam logic [13:0] SYNC_FROM_PINS    = 14'h2aaa;

	typedef enum logic [1:0] {
		SYNC_OFF   = 2'h0,
		SYNC_ONCE  = 2'h1,
		SYNC_PINS  = 2'h2,
		SYNC_OTHER = 2'h3
	} sync_mode_t;

	// ------------------------------------------------------------
	// Control fields carried to the core
	// ------------------------------------------------------------
	typedef struct packed {
		logic       four_wire;
		logic       decimate_enable;
		logic       chan_a_filter_type;
		logic       chan_b_filter_type;
		logic       chan_a_autocorrect_enable;
		logic       chan_b_autocorrect_enable;
		logic       performance_setting_one;
		logic [3:0] overload_threshold;
		logic       chan_a_offset_loop_start;
		sync_mode_t sync_mode;
	} ctrl_fields_t;

	// A finished frame handed from the link domain to the core.
	typedef struct packed {
		logic [6:0]  addr;
		logic [15:0] data;
	} wr_frame_t;

endpackage : config_port_pkg

// ---- design/config_port.sv ----
`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// - Default three wire, shared bidirectional data
// - Reg 0 bit 15 selects wire mode
// - Frame is 8 address, 16 data bits
// - Eighth rising edge latches read flag
// - Bit 7 flag, bits 6-0 address
// - Write samples 16 bits on rising edges
// - Read shifts out all 16 bits
// - Read flag latched into write_lock_ff, which blocks nothing
// - Hardware or software reset loads defaults
// - Soft reset restores defaults, self clears
// - Reg 0 bit 14 enables decimation
// - Reg 1 bits 15, 9 autocorrect enables
// - Over-range threshold bits 10-7, default 15
// - Reg 3 bit 14 starts offset loop
// - Sync selection field encodings decoded
// - One write changes several fields
module config_port
	import config_port_pkg::*;
(
	input  wire logic                         mclk,
	input  wire logic                         rst,
	input  wire logic                         clk_en,
	input  wire logic                         hardware_reset_n,
	input  wire logic                         sclk,
	input  wire logic                         serial_select_n,
	input  wire logic                         sdio_in,
	output logic                              sdio_out,
	output logic                              sdio_oe,
	output logic                              serial_read_out,
	input  wire logic [8:0]                   temperature_value,
	output config_port_pkg::ctrl_fields_t     ctrl
);
	import config_port_pkg::*;

	// ------------------------------------------------------------
	// Register bank in the core domain
	// ------------------------------------------------------------
	logic [15:0] iface_filter_ff;
	logic [15:0] corr_format_ff;
	logic [15:0] ovr_thresh_ff;
	logic [15:0] cha_corr_ff;
	logic [15:0] sync_low_ff;
	logic [15:0] sync_high_ref_ff;
	logic [15:0] chb_corr_ff;
	logic [15:0] sleep_mode_ff;
	logic [15:0] bias_power_ff;
	logic [15:0] out_driver_ff;
	logic [15:0] cha_pins_ff;
	logic [15:0] chb_pins_ff;
	logic [15:0] soft_reset_ff;

	// ------------------------------------------------------------
	// Link domain state
	// ------------------------------------------------------------
	logic [4:0]  bit_cnt_ff;
	logic [7:0]  addr_sr_ff;
	logic [15:0] data_sr_ff;
	logic [15:0] rd_sr_ff;
	logic        rd_active_ff;
	logic        write_lock_ff = 1'b0;
	wr_frame_t   wr_hold_ff;
	logic        wr_toggle_ff = 1'b0;
	logic [15:0] rd_word;
	logic        bank_reset;
	logic [13:0] wr_sel;
	logic [1:0]  mode_sync_ff;
	logic        link_four_wire;
	ctrl_fields_t nxt_ctrl;

	// ------------------------------------------------------------
	// Crossing: write toggle and reset into core; mode to link
	// ------------------------------------------------------------
	logic [2:0]  wr_tog_sync_ff;
	logic [1:0]  hw_rst_sync_ff;
	logic        wr_event;

	always_ff @(posedge mclk) begin
		if (rst) begin
			wr_tog_sync_ff <= 3'h0;
		end else if (clk_en) begin
			wr_tog_sync_ff <= {wr_tog_sync_ff[1:0], wr_toggle_ff};
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			hw_rst_sync_ff <= 2'h0;
		end else if (clk_en) begin
			hw_rst_sync_ff <= {hw_rst_sync_ff[0], hardware_reset_n};
		end
	end

	assign wr_event = wr_tog_sync_ff[2] ^ wr_tog_sync_ff[1];

	// ------------------------------------------------------------
	// Bank reset sources
	// ------------------------------------------------------------
	assign bank_reset = rst
		| ~hw_rst_sync_ff[1]
		| (soft_reset_ff == SOFT_RESET_KEY);

	// ------------------------------------------------------------
	// Address decode of a posted write
	// ------------------------------------------------------------
	function automatic logic [13:0] reg_select(input logic [6:0] addr);
		logic [13:0] sel;
		sel = 14'h0000;
		if (addr == OFS_IFACE_FILTER) begin
			sel = 14'h0001;
		end else if (addr == OFS_CORR_FORMAT) begin
			sel = 14'h0002;
		end else if (addr == OFS_OVR_THRESH) begin
			sel = 14'h0004;
		end else if (addr == OFS_CHA_CORR) begin
			sel = 14'h0008;
		end else if (addr == OFS_SYNC_LOW) begin
			sel = 14'h0010;
		end else if (addr == OFS_SYNC_HIGH_REF) begin
			sel = 14'h0020;
		end else if (addr == OFS_CHB_CORR) begin
			sel = 14'h0040;
		end else if (addr == OFS_TEMPERATURE) begin
			sel = 14'h0080;
		end else if (addr == OFS_SOFT_RESET) begin
			sel = 14'h0100;
		end else if (addr == OFS_SLEEP_MODE) begin
			sel = 14'h0200;
		end else if (addr == OFS_BIAS_POWER) begin
			sel = 14'h0400;
		end else if (addr == OFS_OUT_DRIVER) begin
			sel = 14'h0800;
		end else if (addr == OFS_CHA_PINS) begin
			sel = 14'h1000;
		end else if (addr == OFS_CHB_PINS) begin
			sel = 14'h2000;
		end
		return sel;
	endfunction

	assign wr_sel = reg_select(wr_hold_ff.addr);

	// ------------------------------------------------------------
	// Register writes
	// ------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (bank_reset) begin
			iface_filter_ff  <= RST_IFACE_FILTER;
			corr_format_ff   <= RST_CORR_FORMAT;
			ovr_thresh_ff    <= RST_OVR_THRESH;
			cha_corr_ff      <= RST_CHA_CORR;
			sync_low_ff      <= RST_SYNC_LOW;
			sync_high_ref_ff <= RST_SYNC_HIGH_REF;
			chb_corr_ff      <= RST_CHB_CORR;
			sleep_mode_ff    <= RST_SLEEP_MODE;
			bias_power_ff    <= RST_BIAS_POWER;
			out_driver_ff    <= RST_OUT_DRIVER;
			cha_pins_ff      <= RST_PINS;
			chb_pins_ff      <= RST_PINS;
		end else if (clk_en && wr_event) begin
			if (wr_sel[0]) begin
				iface_filter_ff <= wr_hold_ff.data;
			end
			if (wr_sel[1]) begin
				corr_format_ff <= wr_hold_ff.data;
			end
			if (wr_sel[2]) begin
				ovr_thresh_ff <= wr_hold_ff.data;
			end
			if (wr_sel[3]) begin
				cha_corr_ff <= wr_hold_ff.data;
			end
			if (wr_sel[4]) begin
				sync_low_ff <= wr_hold_ff.data;
			end
			if (wr_sel[5]) begin
				sync_high_ref_ff <= wr_hold_ff.data;
			end
			if (wr_sel[6]) begin
				chb_corr_ff <= wr_hold_ff.data;
			end
			if (wr_sel[9]) begin
				sleep_mode_ff <= wr_hold_ff.data;
			end
			if (wr_sel[10]) begin
				bias_power_ff <= wr_hold_ff.data;
			end
			if (wr_sel[11]) begin
				out_driver_ff <= wr_hold_ff.data;
			end
			if (wr_sel[12]) begin
				cha_pins_ff <= wr_hold_ff.data;
			end
			if (wr_sel[13]) begin
				chb_pins_ff <= wr_hold_ff.data;
			end
		end
	end

	// ------------------------------------------------------------
	// Software reset key register
	// ------------------------------------------------------------
	// The key fires a bank reset, which then clears the key itself.
	always_ff @(posedge mclk) begin
		if (bank_reset) begin
			soft_reset_ff <= 16'h0000;
		end else if (clk_en && wr_event && wr_sel[8]) begin
			soft_reset_ff <= wr_hold_ff.data;
		end
	end

	// ------------------------------------------------------------
	// Read multiplexer
	// ------------------------------------------------------------
	// Registers only change between frames, so the link reads them steadily.
	always_comb begin
		rd_word = 16'h0000;
		if (addr_sr_ff[6:0] == OFS_IFACE_FILTER) begin
			rd_word = iface_filter_ff;
		end else if (addr_sr_ff[6:0] == OFS_CORR_FORMAT) begin
			rd_word = corr_format_ff;
		end else if (addr_sr_ff[6:0] == OFS_OVR_THRESH) begin
			rd_word = ovr_thresh_ff;
		end else if (addr_sr_ff[6:0] == OFS_CHA_CORR) begin
			rd_word = cha_corr_ff;
		end else if (addr_sr_ff[6:0] == OFS_SYNC_LOW) begin
			rd_word = sync_low_ff;
		end else if (addr_sr_ff[6:0] == OFS_SYNC_HIGH_REF) begin
			rd_word = sync_high_ref_ff;
		end else if (addr_sr_ff[6:0] == OFS_CHB_CORR) begin
			rd_word = chb_corr_ff;
		end else if (addr_sr_ff[6:0] == OFS_TEMPERATURE) begin
			rd_word = {7'h00, temperature_value};
		end else if (addr_sr_ff[6:0] == OFS_SOFT_RESET) begin
			rd_word = soft_reset_ff;
		end else if (addr_sr_ff[6:0] == OFS_SLEEP_MODE) begin
			rd_word = sleep_mode_ff;
		end else if (addr_sr_ff[6:0] == OFS_BIAS_POWER) begin
			rd_word = bias_power_ff;
		end else if (addr_sr_ff[6:0] == OFS_OUT_DRIVER) begin
			rd_word = out_driver_ff;
		end else if (addr_sr_ff[6:0] == OFS_CHA_PINS) begin
			rd_word = cha_pins_ff;
		end else if (addr_sr_ff[6:0] == OFS_CHB_PINS) begin
			rd_word = chb_pins_ff;
		end
	end

	// ------------------------------------------------------------
	// Serial link, clocked by sclk, framed by select
	// ------------------------------------------------------------
	always_ff @(posedge sclk or posedge serial_select_n) begin
		if (serial_select_n) begin
			bit_cnt_ff <= 5'h00;
			rd_active_ff <= 1'b0;
		end else if (bit_cnt_ff != 5'(FRAME_BITS)) begin
			bit_cnt_ff <= bit_cnt_ff + 5'h01;
			if (bit_cnt_ff == 5'(ADDR_BITS - 1)) begin
				rd_active_ff <= addr_sr_ff[6];
			end
		end
	end

	// ------------------------------------------------------------
	// Address and data shift registers
	// ------------------------------------------------------------
	always_ff @(posedge sclk) begin
		if (!serial_select_n) begin
			if (bit_cnt_ff < 5'(ADDR_BITS)) begin
				addr_sr_ff <= {addr_sr_ff[6:0], sdio_in};
			end else if (bit_cnt_ff < 5'(FRAME_BITS)) begin
				data_sr_ff <= {data_sr_ff[14:0], sdio_in};
			end
		end
	end

	// ------------------------------------------------------------
	// Read data shifter
	// ------------------------------------------------------------
	always_ff @(negedge sclk) begin
		if (bit_cnt_ff == 5'(ADDR_BITS) && rd_active_ff) begin
			rd_sr_ff <= rd_word;
		end else if (rd_active_ff) begin
			rd_sr_ff <= {rd_sr_ff[14:0], 1'b0};
		end
	end

	// ------------------------------------------------------------
	// Frame posting when select rises after 24 bits
	// ------------------------------------------------------------
	always_ff @(posedge serial_select_n) begin
		if (bit_cnt_ff == 5'(FRAME_BITS)) begin
			write_lock_ff <= addr_sr_ff[RW_POS];
		end
	end

	always_ff @(posedge serial_select_n) begin
		if (bit_cnt_ff == 5'(FRAME_BITS)) begin
			if (!addr_sr_ff[RW_POS]) begin
				wr_hold_ff <= '{addr: addr_sr_ff[6:0], data: data_sr_ff};
				wr_toggle_ff <= ~wr_toggle_ff;
			end
		end
	end

	// ------------------------------------------------------------
	// Wire mode carried into the link domain
	// ------------------------------------------------------------
	// The mode bit changes only between frames; two edges settle it.
	always_ff @(posedge sclk) begin
		mode_sync_ff <= {mode_sync_ff[0], iface_filter_ff[FLD_FOUR_WIRE]};
	end

	assign link_four_wire = mode_sync_ff[1];

	// ------------------------------------------------------------
	// Pad drivers
	// ------------------------------------------------------------
	assign sdio_oe = rd_active_ff && !link_four_wire
		&& !serial_select_n
		&& bit_cnt_ff >= 5'(ADDR_BITS);
	assign sdio_out = rd_sr_ff[15];
	assign serial_read_out = (rd_active_ff && link_four_wire)
		? rd_sr_ff[15] : 1'b0;

	// ------------------------------------------------------------
	// Control field outputs
	// ------------------------------------------------------------
	always_comb begin
		nxt_ctrl.four_wire = iface_filter_ff[FLD_FOUR_WIRE];
		nxt_ctrl.decimate_enable = iface_filter_ff[FLD_DECIMATE];
		nxt_ctrl.chan_a_filter_type = iface_filter_ff[FLD_CHA_FILTER]
			& iface_filter_ff[FLD_DECIMATE];
		nxt_ctrl.chan_b_filter_type = iface_filter_ff[FLD_CHB_FILTER]
			& iface_filter_ff[FLD_DECIMATE];
		nxt_ctrl.chan_a_autocorrect_enable
			= corr_format_ff[FLD_CHA_AUTOCORR];
		nxt_ctrl.chan_b_autocorrect_enable
			= corr_format_ff[FLD_CHB_AUTOCORR];
		nxt_ctrl.performance_setting_one = corr_format_ff[FLD_PERF_ONE];
		nxt_ctrl.overload_threshold
			= ovr_thresh_ff[FLD_OVR_LSB +: 4];
		nxt_ctrl.chan_a_offset_loop_start
			= cha_corr_ff[FLD_OFFSET_LOOP];
		if (sync_low_ff[FLD_SYNC_LSB +: 14] == SYNC_DISABLED) begin
			nxt_ctrl.sync_mode = SYNC_OFF;
		end else if (sync_low_ff[FLD_SYNC_LSB +: 14] == SYNC_ONE_SHOT) begin
			nxt_ctrl.sync_mode = SYNC_ONCE;
		end else if (sync_low_ff[FLD_SYNC_LSB +: 14] == SYNC_FROM_PINS) begin
			nxt_ctrl.sync_mode = SYNC_PINS;
		end else begin
			nxt_ctrl.sync_mode = SYNC_OTHER;
		end
	end

	// ------------------------------------------------------------
	// Control fields registered onto the output
	// ------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (rst || clk_en) begin
			ctrl <= nxt_ctrl;
		end
	end

endmodule // config_port

`default_nettype wire

// ---- test/config_port_chk.sv ----
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------
// Port checks
// ------------------------------------------------
module config_port_chk
	import config_port_pkg::*;
(
	input wire logic                     mclk,
	input wire logic                     rst,
	input wire logic                     hardware_reset_n,
	input wire logic                     serial_select_n,
	input wire logic                     sdio_oe,
	input wire logic                     serial_read_out,
	input wire config_port_pkg::ctrl_fields_t ctrl
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	sequence s_hw_low;
		!hardware_reset_n [*6];
	endsequence
	sequence s_in_frame;
		(!serial_select_n && hardware_reset_n) [*8];
	endsequence
	property p_oe_frame;
		sdio_oe |-> !serial_select_n;
	endproperty
	property p_oe_three;
		sdio_oe |-> !ctrl.four_wire;
	endproperty
	property p_out_three;
		!ctrl.four_wire |-> !serial_read_out;
	endproperty
	property p_gate;
		!ctrl.decimate_enable |->
			!ctrl.chan_a_filter_type && !ctrl.chan_b_filter_type;
	endproperty
	property p_rst_bits;
		$fell(rst) |-> !ctrl.four_wire && !ctrl.decimate_enable &&
			!ctrl.chan_a_autocorrect_enable &&
			!ctrl.chan_b_autocorrect_enable && !ctrl.performance_setting_one;
	endproperty
	property p_rst_sync;
		$fell(rst) |-> ctrl.sync_mode == SYNC_PINS;
	endproperty
	property p_hw;
		s_hw_low |-> ctrl.overload_threshold == 4'hf &&
			ctrl.chan_a_offset_loop_start;
	endproperty
	property p_frame;
		s_in_frame |=> $stable(ctrl);
	endproperty
	a_oe_frame: assert property (p_oe_frame)
		else $error("shared line driven outside a frame");
	a_oe_three: assert property (p_oe_three)
		else $error("shared line driven in four wire mode");
	a_out_three: assert property (p_out_three)
		else $error("read output active in three wire mode");
	a_gate: assert property (p_gate)
		else $error("filter type active without decimation");
	a_rst_bits: assert property (p_rst_bits)
		else $error("control bits not cleared by reset");
	a_rst_sync: assert property (p_rst_sync)
		else $error("sync mode not pins after reset");
	a_hw: assert property (p_hw)
		else $error("hardware reset did not load defaults");
	a_frame: assert property (p_frame)
		else $error("controls changed inside a frame");
endmodule // config_port_chk
`default_nettype wire

// ---- test/serial_master.sv ----
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------
// Serial controller model
// ------------------------------------------------
module serial_master (
	output logic      sclk,
	output logic      serial_select_n,
	output logic      drv_bit,
	output logic      drv_oe,
	input  wire logic wire_level,
	input  wire logic serial_read_out
);
	initial begin
		sclk = 1'b0;
		serial_select_n = 1'b1;
		drv_bit = 1'b0;
		drv_oe = 1'b0;
	end
	task automatic xfer(input logic [23:0] f, input int nb,
			input logic fw, output logic [15:0] rd);
		rd = 16'h0000;
		#7 serial_select_n = 1'b0;
		drv_oe = 1'b1;
		for (int i = 0; i < nb; i++) begin
			if (i == 8 && f[23]) drv_oe = 1'b0;
			drv_bit = f[23 - i];
			#80 sclk = 1'b1;
			if (i >= 8) rd = {rd[14:0], fw ? serial_read_out : wire_level};
			#80 sclk = 1'b0;
		end
		#80 serial_select_n = 1'b1;
		drv_oe = 1'b0;
		#400;
	endtask
endmodule // serial_master
`default_nettype wire

// ---- test/config_port_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------
// Bench
// ------------------------------------------------
module config_port_tb;
	import config_port_pkg::*;
	logic         mclk, rst, hardware_reset_n;
	logic         sclk, serial_select_n, drv_bit, drv_oe;
	logic         sdio_out, sdio_oe, serial_read_out;
	wire logic    sdio_wire;
	ctrl_fields_t ctrl, exp_c;
	logic [15:0]  rd;
	int           n_mismatch = 0;
	int           tests_run = 0;
	int           cyc = 0;
	assign sdio_wire = sdio_oe ? sdio_out : (drv_oe ? drv_bit : ~drv_bit);
	serial_master m (.sclk(sclk), .serial_select_n(serial_select_n),
		.drv_bit(drv_bit), .drv_oe(drv_oe), .wire_level(sdio_wire),
		.serial_read_out(serial_read_out));
	config_port dut (.mclk(mclk), .rst(rst), .clk_en(1'b1),
		.hardware_reset_n(hardware_reset_n), .sclk(sclk),
		.serial_select_n(serial_select_n), .sdio_in(sdio_wire),
		.sdio_out(sdio_out), .sdio_oe(sdio_oe),
		.serial_read_out(serial_read_out),
		.temperature_value(9'h1a5), .ctrl(ctrl));
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			n_mismatch++;
			close_out();
		end
	end
	task automatic close_out();
		$display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
		if (n_mismatch == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic compare(input logic [15:0] g, input logic [15:0] e,
			input string s);
		tests_run++;
		if (g !== e) begin
			n_mismatch++;
			$display("unexpected %0t %s got %h exp %h", $time, s, g, e);
		end
	endtask
	task automatic wr(input logic [6:0] a, input logic [15:0] d, input int nb);
		@(negedge mclk);
		m.xfer({1'b0, a, d}, nb, 1'b0, rd);
	endtask
	task automatic rdc(input logic [6:0] a, input logic [15:0] e, input logic fw);
		@(negedge mclk);
		m.xfer({1'b1, a, 16'h0000}, 24, fw, rd);
		compare(rd, e, "read data");
		compare({2'h0, ctrl}, {2'h0, exp_c}, "control fields");
	endtask
	task automatic dflt();
		exp_c = '0;
		exp_c.overload_threshold = 4'hf;
		exp_c.chan_a_offset_loop_start = 1'b1;
		exp_c.sync_mode = SYNC_PINS;
	endtask
	task automatic t_defaults();
		logic [6:0]  a[14] = '{7'h00, 7'h01, 7'h02, 7'h03, 7'h0e, 7'h0f,
			7'h1a, 7'h2b, 7'h2c, 7'h37, 7'h38, 7'h3a, 7'h66, 7'h67};
		logic [15:0] e[14] = '{16'h0000, 16'h0000, 16'h0780, 16'h4b18,
			16'haaa8, RST_SYNC_HIGH_REF, 16'h4b18, 16'h01a5, 16'h0000,
			RST_SLEEP_MODE, RST_BIAS_POWER, RST_OUT_DRIVER, RST_PINS, RST_PINS};
		for (int i = 0; i < 14; i++) begin
			rdc(a[i], e[i], 1'b0);
		end
	endtask
	task automatic t_fields();
		wr(OFS_IFACE_FILTER, 16'h5200, 24);
		exp_c.decimate_enable = 1'b1;
		exp_c.chan_a_filter_type = 1'b1;
		exp_c.chan_b_filter_type = 1'b1;
		rdc(OFS_IFACE_FILTER, 16'h5200, 1'b0);
		wr(OFS_IFACE_FILTER, 16'h1200, 24);
		exp_c.decimate_enable = 1'b0;
		exp_c.chan_a_filter_type = 1'b0;
		exp_c.chan_b_filter_type = 1'b0;
		rdc(OFS_IFACE_FILTER, 16'h1200, 1'b0);
		wr(OFS_CORR_FORMAT, 16'h8202, 24);
		exp_c.chan_a_autocorrect_enable = 1'b1;
		exp_c.chan_b_autocorrect_enable = 1'b1;
		exp_c.performance_setting_one = 1'b1;
		rdc(OFS_CORR_FORMAT, 16'h8202, 1'b0);
		wr(OFS_OVR_THRESH, 16'h0280, 24);
		exp_c.overload_threshold = 4'h5;
		rdc(OFS_OVR_THRESH, 16'h0280, 1'b0);
		wr(OFS_CHA_CORR, 16'h0b18, 24);
		exp_c.chan_a_offset_loop_start = 1'b0;
		rdc(OFS_CHA_CORR, 16'h0b18, 1'b0);
	endtask
	task automatic t_sync();
		logic [13:0] c[4] = '{14'h0000, 14'h1555, 14'h2aaa, 14'h3fff};
		sync_mode_t  md[4] = '{SYNC_OFF, SYNC_ONCE, SYNC_PINS, SYNC_OTHER};
		for (int i = 0; i < 4; i++) begin
			wr(OFS_SYNC_LOW, {c[i], 2'h0}, 24);
			exp_c.sync_mode = md[i];
			rdc(OFS_SYNC_LOW, {c[i], 2'h0}, 1'b0);
		end
	endtask
	task automatic t_resets();
		wr(OFS_OVR_THRESH, 16'h0400, 20);
		wr(OFS_OVR_THRESH, 16'h0400, 7);
		rdc(OFS_OVR_THRESH, 16'h0280, 1'b0);
		wr(OFS_SOFT_RESET, 16'hd2f1, 24);
		rdc(OFS_OVR_THRESH, 16'h0280, 1'b0);
		wr(OFS_SOFT_RESET, 16'hd2f0, 24);
		dflt();
		t_defaults();
		wr(OFS_IFACE_FILTER, 16'h8000, 24);
		exp_c.four_wire = 1'b1;
		rdc(OFS_IFACE_FILTER, 16'h8000, 1'b1);
		rdc(OFS_CHB_CORR, 16'h4b18, 1'b1);
		wr(OFS_OVR_THRESH, 16'h0280, 24);
		@(negedge mclk);
		hardware_reset_n = 1'b0;
		repeat (8) @(negedge mclk);
		hardware_reset_n = 1'b1;
		repeat (6) @(negedge mclk);
		dflt();
		t_defaults();
	endtask
	initial begin
		rst = 1'b1;
		hardware_reset_n = 1'b1;
		repeat (12) @(negedge mclk);
		rst = 1'b0;
		dflt();
		t_defaults();
		t_fields();
		t_sync();
		t_resets();
		close_out();
	end
endmodule // config_port_tb
bind config_port config_port_chk port_check (.mclk(mclk), .rst(rst),
	.hardware_reset_n(hardware_reset_n),
	.serial_select_n(serial_select_n), .sdio_oe(sdio_oe),
	.serial_read_out(serial_read_out), .ctrl(ctrl));
`default_nettype wire
